// ---- design/ced_top.sv ----
/*
  Comparator event block: compares the synchronised analog levels, samples the result once
  per machine cycle and raises the compare event flag on level, edge or toggle conditions,
  optionally debounced by Timer 1 overflows. Registers sit on an APB slave.
  Assumes timer1_overflow, idle_mode, power_down_mode and single_speed_clock_mode come from
  logic on pclk; the analog level words are quasi-static pin inputs.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
// How it works
// - Result is one when positive input exceeds negative input, else zero.
// - Comparison and event detection run only while comparator enable is set.
// - Flag is set whenever sampled result meets the selected condition.
// - Flag is polled or interrupts; only a software write clears it.
// - Idle or power-down forces the comparator off; no events there.
// - Result sampled once per machine cycle at fourth state phase.
// - Debounced modes wait two Timer 1 overflows after a transition, then resample.
// - After the wait, flag set only if new sample matches expected value.
// - Debounced flag rises one to two Timer 1 periods after the transition.
// - Mode field decodes low, rise, dtoggle, drise, fall, toggle, dfall, high.
// - Clearing enable forces the result low and blocks further events.
// - Comparator interrupt is gated by bit 6 of the interrupt mask register.
// - In single speed mode a machine cycle spans 12 system clocks.
`timescale 1ns/1ps
`default_nettype none

module ced_top #(
  parameter int unsigned AIN_W = 8
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ced_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ced_pkg::DATA_W-1:0] pwdata,
  output logic      [ced_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [AIN_W-1:0]          positive_analog_input,
  input  wire logic [AIN_W-1:0]          negative_analog_input,
  input  wire logic                      timer1_overflow,
  input  wire logic                      idle_mode,
  input  wire logic                      power_down_mode,
  input  wire logic                      single_speed_clock_mode,
  output logic                           comparator_result,
  output logic                           comparator_irq,
  output logic                           event_irq
);
  import ced_pkg::*;

  // Condition met directly on a sample
  function automatic logic cond_hit(input logic [MODE_W-1:0] m, input logic prv,
                                    input logic cur);
    case (m)
      MD_LOW:    cond_hit = ~cur;
      MD_RISE:   cond_hit = ~prv & cur;
      MD_FALL:   cond_hit = prv & ~cur;
      MD_TOGGLE: cond_hit = prv ^ cur;
      MD_HIGH:   cond_hit = cur;
      default:   cond_hit = 1'b0;
    endcase
  endfunction : cond_hit

  // Transition that opens a debounce wait
  function automatic logic deb_start(input logic [MODE_W-1:0] m, input logic prv,
                                     input logic cur);
    case (m)
      MD_DTOGGLE: deb_start = prv ^ cur;
      MD_DRISE:   deb_start = ~prv & cur;
      MD_DFALL:   deb_start = prv & ~cur;
      default:    deb_start = 1'b0;
    endcase
  endfunction : deb_start

  logic [AIN_W-1:0]    pos_q;
  logic [AIN_W-1:0]    neg_q;
  logic                en_ff;
  logic [MODE_W-1:0]   mode_ff;
  logic                flag_ff;
  logic                imask_cmp_ff;
  logic [EV_W-1:0]     ev_st_ff;
  logic [EV_W-1:0]     ev_mask_ff;
  logic [PHASE_W-1:0]  phase_ff;
  logic                sample_ff;
  logic                expect_ff;
  logic [OVF_W-1:0]    ovf_cnt_ff;
  ced_state_t          state_ff;
  logic [SETTLE_W-1:0] settle_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  logic [DATA_W-1:0]   prdata_ff;
  logic                result_ff;
  logic                cmp_irq_ff;
  logic                ev_irq_ff;

  ced_state_t          nxt_state;
  logic [OVF_W-1:0]    nxt_ovf;
  logic                nxt_expect;
  logic                hw_set;
  logic                hw_rej;

  ced_sync #(.WIDTH(AIN_W)) u_sync_pos (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (positive_analog_input),
    .q     (pos_q)
  );

  ced_sync #(.WIDTH(AIN_W)) u_sync_neg (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (negative_analog_input),
    .q     (neg_q)
  );

  // Enable gating and the compare itself
  wire run     = en_ff & ~idle_mode & ~power_down_mode;
  wire cmp_now = run & (pos_q > neg_q);

  // Machine cycle framing
  wire [PHASE_W-1:0] mc_last      = single_speed_clock_mode ? MC_LAST_SINGLE
                                                            : MC_LAST_DOUBLE;
  wire [PHASE_W-1:0] sample_phase = single_speed_clock_mode ? SAMPLE_PHASE_SINGLE
                                                            : SAMPLE_PHASE_DOUBLE;
  wire [PHASE_W-1:0] nxt_phase = (phase_ff >= mc_last) ? PHASE_ZERO : phase_ff + PHASE_ONE;
  wire sample_tick = (phase_ff == sample_phase);

  // APB decode; one wait state so read data can come from a flip-flop
  wire acc_first = psel & penable & ~pready_ff;
  wire xfer_done = psel & penable & pready_ff;
  wire wr_en     = xfer_done & pwrite;
  wire rd_en     = xfer_done & ~pwrite;
  wire hit_ctrl  = (paddr == CTRL_ADDR);
  wire hit_imask = (paddr == IMASK_ADDR);
  wire hit_evst  = (paddr == EVST_ADDR);
  wire hit_evmsk = (paddr == EVMSK_ADDR);
  wire hit_state = (paddr == STATE_ADDR);
  wire mapped    = hit_ctrl | hit_imask | hit_evst | hit_evmsk | hit_state;

  wire settled = (settle_ff == SETTLE_LAST);
  wire busy    = (state_ff == ST_WAIT) | (state_ff == ST_RESAMPLE);

  wire [DATA_W-1:0] rd_ctrl  = (DATA_W'(flag_ff) << CTRL_FLAG_BIT)
                             | (DATA_W'(en_ff) << CTRL_EN_BIT)
                             | (DATA_W'(mode_ff) << CTRL_MODE_LSB);
  wire [DATA_W-1:0] rd_imask = DATA_W'(imask_cmp_ff) << IMASK_CMP_BIT;
  wire [DATA_W-1:0] rd_state = (DATA_W'(result_ff) << ST_RES_BIT)
                             | (DATA_W'(settled) << ST_SETTLED_BIT)
                             | (DATA_W'(busy) << ST_BUSY_BIT);
  wire [DATA_W-1:0] rd_mux   = hit_ctrl  ? rd_ctrl :
                               hit_imask ? rd_imask :
                               hit_evst  ? DATA_W'(ev_st_ff) :
                               hit_evmsk ? DATA_W'(ev_mask_ff) :
                               hit_state ? rd_state : DATA_ZERO;

  // Flag: hardware set wins over a software clear in the same cycle
  wire wr_ctrl = wr_en & hit_ctrl;
  wire nxt_flag = hw_set | (wr_ctrl ? pwdata[CTRL_FLAG_BIT] : flag_ff);

  // Clear on read drops only the bits that were returned, so a late event survives
  wire [EV_W-1:0] rd_clr = (rd_en & hit_evst) ? prdata_ff[EV_W-1:0] : EV_ZERO;
  wire [EV_W-1:0] ev_new = (EV_W'(hw_set) << EV_SET_BIT) | (EV_W'(hw_rej) << EV_REJ_BIT);
  wire [EV_W-1:0] nxt_ev = ev_new | (ev_st_ff & ~rd_clr);

  wire [SETTLE_W-1:0] nxt_settle = !run ? '0 :
                                   settled ? settle_ff : settle_ff + SETTLE_W'(1);

  // Detection and debounce sequencing
  always_comb begin
    nxt_state  = state_ff;
    nxt_ovf    = ovf_cnt_ff;
    nxt_expect = expect_ff;
    hw_set     = 1'b0;
    hw_rej     = 1'b0;
    case (state_ff)
      ST_OFF: begin
        if (run) nxt_state = ST_WATCH;
      end
      ST_WATCH: begin
        if (sample_tick) begin
          if (cond_hit(mode_ff, sample_ff, cmp_now)) begin
            hw_set = 1'b1;
          end else if (deb_start(mode_ff, sample_ff, cmp_now)) begin
            nxt_state  = ST_WAIT;
            nxt_ovf    = OVF_ZERO;
            nxt_expect = cmp_now;
          end
        end
      end
      ST_WAIT: begin
        // Free-running timer: second overflow guarantees at least one full period
        if (timer1_overflow) begin
          if (ovf_cnt_ff == OVF_LAST) nxt_state = ST_RESAMPLE;
          else nxt_ovf = ovf_cnt_ff + OVF_ONE;
        end
      end
      ST_RESAMPLE: begin
        if (sample_tick) begin
          if (cmp_now == expect_ff) hw_set = 1'b1;
          else hw_rej = 1'b1;
          nxt_state = ST_WATCH;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
    if (!run) begin
      nxt_state = ST_OFF;
      hw_set    = 1'b0;
      hw_rej    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff   <= PHASE_ZERO;
      sample_ff  <= 1'b0;
      expect_ff  <= 1'b0;
      ovf_cnt_ff <= OVF_ZERO;
      state_ff   <= ST_OFF;
      settle_ff  <= '0;
      result_ff  <= 1'b0;
    end else begin
      phase_ff   <= nxt_phase;
      sample_ff  <= !run ? 1'b0 : (sample_tick ? cmp_now : sample_ff);
      expect_ff  <= nxt_expect;
      ovf_cnt_ff <= nxt_ovf;
      state_ff   <= nxt_state;
      settle_ff  <= nxt_settle;
      result_ff  <= cmp_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff      <= 1'b0;
      mode_ff    <= MODE_RST;
      flag_ff      <= 1'b0;
      imask_cmp_ff <= 1'b0;
      ev_st_ff   <= EV_ZERO;
      ev_mask_ff <= EV_ZERO;
    end else begin
      if (wr_ctrl) en_ff <= pwdata[CTRL_EN_BIT];
      if (wr_ctrl) mode_ff <= pwdata[CTRL_MODE_LSB +: MODE_W];
      flag_ff <= nxt_flag;
      if (wr_en & hit_imask) imask_cmp_ff <= pwdata[IMASK_CMP_BIT];
      ev_st_ff <= nxt_ev;
      if (wr_en & hit_evmsk) ev_mask_ff <= pwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= DATA_ZERO;
      cmp_irq_ff <= 1'b0;
      ev_irq_ff  <= 1'b0;
    end else begin
      pready_ff  <= acc_first;
      pslverr_ff <= acc_first & ~mapped;
      prdata_ff  <= (acc_first & ~pwrite) ? rd_mux : DATA_ZERO;
      cmp_irq_ff <= flag_ff & imask_cmp_ff;
      ev_irq_ff  <= |(ev_st_ff & ev_mask_ff);
    end
  end

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign comparator_result = result_ff;
  assign comparator_irq    = cmp_irq_ff;
  assign event_irq         = ev_irq_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_result_compare: assert property (
    ##1 result_ff == $past(run & (pos_q > neg_q)))
    else $error("comparator result does not follow the input compare");

  a_disabled_quiet: assert property (
    !en_ff |=> !result_ff && (state_ff == ST_OFF))
    else $error("disabled comparator still active");

  a_flag_sticky: assert property (
    flag_ff && !wr_ctrl |=> flag_ff)
    else $error("compare event flag dropped without a write");

  a_sleep_off: assert property (
    (idle_mode || power_down_mode) |=> state_ff == ST_OFF && !sample_ff)
    else $error("comparator active in idle or power-down");

  a_sample_spacing_single: assert property (
    sample_tick && single_speed_clock_mode && phase_ff <= MC_LAST_SINGLE
      ##1 single_speed_clock_mode |-> (!sample_tick)[*8])
    else $error("sample phase repeats too soon in single speed mode");

  // Six clocks per machine cycle: next sample tick one cycle after the five idle ones
  a_sample_period_double: assert property (
    sample_tick && !single_speed_clock_mode ##1 !single_speed_clock_mode [*5]
      |=> sample_tick)
    else $error("sample phase not once per machine cycle in double speed mode");

  a_two_ovf_wait: assert property (
    state_ff == ST_WAIT && run && timer1_overflow && ovf_cnt_ff == OVF_ZERO
      |=> state_ff == ST_WAIT)
    else $error("debounce wait ended after one overflow");

  a_deb_accept: assert property (
    state_ff == ST_RESAMPLE && run && sample_tick && cmp_now == expect_ff |=> flag_ff)
    else $error("matching resample did not set the flag");

  a_deb_reject: assert property (
    state_ff == ST_RESAMPLE && run && sample_tick && cmp_now != expect_ff
      |=> state_ff == ST_WATCH && ev_st_ff[EV_REJ_BIT])
    else $error("mismatching resample not discarded");

  a_level_high: assert property (
    state_ff == ST_WATCH && run && sample_tick && mode_ff == MD_HIGH && cmp_now |=> flag_ff)
    else $error("high level mode did not set the flag");

  a_irq_gate: assert property (
    ##2 comparator_irq == $past(flag_ff & imask_cmp_ff, 1))
    else $error("comparator interrupt not gated by its mask bit");

  c_edge_event: cover property (
    state_ff == ST_WATCH && sample_tick && mode_ff == MD_FALL && hw_set);
  c_deb_accept: cover property (state_ff == ST_RESAMPLE && hw_set);
  c_deb_reject: cover property (state_ff == ST_RESAMPLE && hw_rej);
  c_irq_raise:  cover property (!comparator_irq ##1 comparator_irq);

endmodule : ced_top

`default_nettype wire

// ---- design/ced_pkg.sv ----
/*
  Constants, field layout, register map, modes and states of the comparator event block.
  Assumes a 25 MHz APB clock and a 32-bit APB data path.
*/
`default_nettype none

package ced_pkg;

  // Clock and settling time
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SETTLE_TIME_NS = 10000;
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W       = 9;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES);

  // Machine cycle framing, in system clocks
  localparam int unsigned PHASE_W     = 4;
  localparam int unsigned MC_CLKS_SINGLE = 12;
  localparam int unsigned MC_CLKS_DOUBLE = 6;
  localparam logic [PHASE_W-1:0] MC_LAST_SINGLE      = PHASE_W'(MC_CLKS_SINGLE - 1);
  localparam logic [PHASE_W-1:0] MC_LAST_DOUBLE      = PHASE_W'(MC_CLKS_DOUBLE - 1);
  localparam logic [PHASE_W-1:0] SAMPLE_PHASE_SINGLE = 4'h7;
  localparam logic [PHASE_W-1:0] SAMPLE_PHASE_DOUBLE = 4'h3;
  localparam logic [PHASE_W-1:0] PHASE_ZERO  = 4'h0;
  localparam logic [PHASE_W-1:0] PHASE_ONE   = 4'h1;

  // Debounce wait: two Timer 1 overflows
  localparam int unsigned OVF_W = 2;
  localparam logic [OVF_W-1:0] OVF_ZERO = 2'h0;
  localparam logic [OVF_W-1:0] OVF_ONE  = 2'h1;
  localparam logic [OVF_W-1:0] OVF_LAST = 2'h1;

  // APB
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h097;
  localparam logic [ADDR_W-1:0] CTRL_ADDR  = CTRL_INDEX << 2;
  localparam logic [ADDR_W-1:0] IMASK_ADDR = 12'h260;
  localparam logic [ADDR_W-1:0] EVST_ADDR  = 12'h264;
  localparam logic [ADDR_W-1:0] EVMSK_ADDR = 12'h268;
  localparam logic [ADDR_W-1:0] STATE_ADDR = 12'h26C;

  // Control and status fields
  localparam int unsigned MODE_W      = 3;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_EN_BIT = 3;
  localparam int unsigned CTRL_FLAG_BIT = 4;
  localparam int unsigned IMASK_CMP_BIT = 6;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;

  // Event status and mask layout
  localparam int unsigned EV_W       = 2;
  localparam int unsigned EV_SET_BIT = 0;
  localparam int unsigned EV_REJ_BIT = 1;
  localparam logic [EV_W-1:0] EV_ZERO = 2'h0;

  // Live state register layout
  localparam int unsigned ST_RES_BIT     = 0;
  localparam int unsigned ST_SETTLED_BIT = 1;
  localparam int unsigned ST_BUSY_BIT    = 2;

  typedef enum logic [MODE_W-1:0] {
    MD_LOW     = 3'h0,
    MD_RISE    = 3'h1,
    MD_DTOGGLE = 3'h2,
    MD_DRISE   = 3'h3,
    MD_FALL    = 3'h4,
    MD_TOGGLE  = 3'h5,
    MD_DFALL   = 3'h6,
    MD_HIGH    = 3'h7
  } ced_mode_t;

  typedef enum logic [3:0] {
    ST_OFF      = 4'h1,
    ST_WATCH    = 4'h2,
    ST_WAIT     = 4'h4,
    ST_RESAMPLE = 4'h8
  } ced_state_t;

endpackage : ced_pkg

`default_nettype wire

// ---- design/ced_sync.sv ----
/*
  Two flip-flop synchroniser for a word of pin inputs.
  Assumes the word moves slowly compared with the clock, so bits may cross on different edges.
*/
`timescale 1ns/1ps
`default_nettype none

module ced_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : ced_sync

`default_nettype wire

// ---- tb/ced_far_model.sv ----
/*
  Far-side model: the two analog comparator levels and a free-running Timer 1.
  Assumes level_cmd comes from the bench on pclk; overflow is a one-cycle pulse on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module ced_far_model #(
  parameter int unsigned OVF_PER = 40
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] level_cmd,
  output logic      [7:0] pos_level,
  output logic      [7:0] neg_level,
  output logic            timer1_overflow
);
  logic [7:0] tick_ff;
  logic [7:0] nxt_tick;

  // Code 2 gives equal levels, the boundary where the result must stay zero
  assign neg_level = 8'h80;
  assign pos_level = (level_cmd == 2'h1) ? 8'h81 : (level_cmd == 2'h2) ? 8'h80 : 8'h7F;

  // Free running, so the debounce wait starts at an arbitrary timer phase
  assign nxt_tick = (tick_ff == 8'(OVF_PER - 1)) ? 8'h00 : tick_ff + 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff         <= 8'h00;
      timer1_overflow <= 1'b0;
    end else begin
      tick_ff         <= nxt_tick;
      timer1_overflow <= (nxt_tick == 8'h00);
    end
  end
endmodule : ced_far_model

`default_nettype wire

// ---- tb/tb.sv ----
/*
  Self-checking bench for the comparator event block: APB tasks and sequenced tests.
  Assumes the far model supplies analog levels and Timer 1; single speed mode except in the final double speed test.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb;
  import ced_pkg::*;
  localparam int unsigned OVF_PER  = 40;
  localparam int unsigned LIMIT    = 20000;
  localparam logic [7:0]  RISE_SET = 8'hAE;
  localparam logic [7:0]  FALL_SET = 8'h75;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic              t1_ovf, idle_mode, power_down_mode, cmp_res, cmp_irq, ev_irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [7:0]        pos_lvl, neg_lvl;
  logic [1:0]        level_cmd;
  logic [2:0]        m;
  logic              single_mode;
  int                failures, tests_run, cycles, n;

  ced_far_model #(.OVF_PER(OVF_PER)) far_u (.pclk(pclk), .presetn(presetn),
    .level_cmd(level_cmd), .pos_level(pos_lvl), .neg_level(neg_lvl), .timer1_overflow(t1_ovf));

  ced_top #(.AIN_W(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .positive_analog_input(pos_lvl), .negative_analog_input(neg_lvl),
    .timer1_overflow(t1_ovf), .idle_mode(idle_mode), .power_down_mode(power_down_mode),
    .single_speed_clock_mode(single_mode), .comparator_result(cmp_res), .comparator_irq(cmp_irq),
    .event_irq(ev_irq));

  always #20 pclk = ~pclk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end

  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
  endtask : idle

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ctrl(input logic en, input logic [2:0] md, input logic cf);
    apb(1'b1, CTRL_ADDR, 32'({cf, en, md}));
  endtask : ctrl

  task automatic flag_is(input logic exp);
    apb(1'b0, CTRL_ADDR, DATA_ZERO);
    `CHK("flag", exp, rd[CTRL_FLAG_BIT]);
  endtask : flag_is

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = DATA_ZERO;
    level_cmd = 2'h0;
    idle_mode = 1'b0;
    power_down_mode = 1'b0;
    single_mode = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, DATA_ZERO);
    `CHK("ctrl_reset", DATA_ZERO, rd);
    apb(1'b0, 12'h000, DATA_ZERO);
    `CHK("unmapped_err", 1'b1, err);
    `CHK("unmapped_data", DATA_ZERO, rd);
    apb(1'b1, CTRL_ADDR, 32'h0000_00E7);
    apb(1'b0, CTRL_ADDR, DATA_ZERO);
    `CHK("ctrl_rw", 32'h0000_0007, rd);
    $display("test registers done");
    // Every mode: steady low, rise, steady high, fall
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      ctrl(1'b0, m, 1'b0);
      level_cmd <= 2'h0;
      ctrl(1'b1, m, 1'b0);
      idle(130);
      ctrl(1'b1, m, 1'b0);
      idle(130);
      flag_is(m == MD_LOW);
      level_cmd <= 2'h1;
      idle(130);
      flag_is(m == MD_LOW || RISE_SET[i]);
      ctrl(1'b1, m, 1'b0);
      idle(130);
      flag_is(m == MD_HIGH);
      level_cmd <= 2'h0;
      idle(130);
      flag_is(m == MD_HIGH || FALL_SET[i]);
    end
    $display("test modes done");
    ctrl(1'b1, MD_HIGH, 1'b0);
    level_cmd <= 2'h1;
    idle(20);
    `CHK("result_above", 1'b1, cmp_res);
    level_cmd <= 2'h2;
    idle(20);
    `CHK("result_equal", 1'b0, cmp_res);
    level_cmd <= 2'h1;
    // Idle, power-down, then plain disable, each with a high level present
    for (int i = 0; i < 3; i++) begin
      idle_mode <= (i == 0);
      power_down_mode <= (i == 1);
      ctrl(i != 2, MD_HIGH, 1'b0);
      idle(40);
      `CHK("result_off", 1'b0, cmp_res);
      flag_is(1'b0);
    end
    idle_mode <= 1'b0;
    power_down_mode <= 1'b0;
    $display("test disable done");
    ctrl(1'b1, MD_DFALL, 1'b0);
    idle(260);
    apb(1'b0, STATE_ADDR, DATA_ZERO);
    `CHK("settled", 1'b1, rd[ST_SETTLED_BIT]);
    apb(1'b0, EVST_ADDR, DATA_ZERO);
    // Short dip: seen by a sample, gone by the resample
    level_cmd <= 2'h0;
    idle(15);
    level_cmd <= 2'h1;
    idle(130);
    flag_is(1'b0);
    apb(1'b0, EVST_ADDR, DATA_ZERO);
    `CHK("reject_status", 32'h0000_0002, rd);
    $display("test debounce reject done");
    apb(1'b1, IMASK_ADDR, 32'h0000_0040);
    apb(1'b1, EVMSK_ADDR, 32'h0000_0001);
    level_cmd <= 2'h0;
    n = 0;
    while (cmp_irq !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    `CHK("irq_delay", 1'b1, n >= OVF_PER && n <= 2 * OVF_PER + 40);
    `CHK("event_irq", 1'b1, ev_irq);
    apb(1'b0, EVST_ADDR, DATA_ZERO);
    `CHK("event_status", 32'h0000_0001, rd);
    idle(3);
    `CHK("event_irq_clear", 1'b0, ev_irq);
    idle(150);
    flag_is(1'b1);
    ctrl(1'b1, MD_DFALL, 1'b0);
    idle(3);
    `CHK("irq_clear", 1'b0, cmp_irq);
    apb(1'b1, IMASK_ADDR, DATA_ZERO);
    ctrl(1'b1, MD_DFALL, 1'b1);
    idle(3);
    `CHK("irq_masked", 1'b0, cmp_irq);
    apb(1'b1, IMASK_ADDR, 32'h0000_0040);
    idle(3);
    `CHK("irq_unmasked", 1'b1, cmp_irq);
    $display("test interrupts done");
    // Six-clock machine cycle: a toggle must be seen within 10 clocks, less than one single speed cycle
    single_mode <= 1'b0;
    ctrl(1'b1, MD_TOGGLE, 1'b0);
    level_cmd <= 2'h1;
    idle(10);
    flag_is(1'b1);
    $display("test double speed done");
    results();
  end
endmodule : tb

`default_nettype wire
